//--- logic/ptc_pkg.sv
package ptc_pkg;
    // bus geometry
    localparam int          PTC_AW        = 8;
    localparam int          PTC_DW        = 32;
    localparam int          PTC_SW        = 4;
    // register byte offsets
    localparam logic [7:0]  PTC_A_CTRL    = 8'h00;
    localparam logic [7:0]  PTC_A_LCONST  = 8'h04;
    localparam logic [7:0]  PTC_A_OCONST  = 8'h08;
    localparam logic [7:0]  PTC_A_PRESET  = 8'h0C;
    localparam logic [7:0]  PTC_A_ACC1    = 8'h10;
    localparam logic [7:0]  PTC_A_ACC2    = 8'h14;
    localparam logic [7:0]  PTC_A_CMP     = 8'h18;
    localparam logic [7:0]  PTC_A_STATUS  = 8'h1C;
    localparam logic [7:0]  PTC_A_COUNT   = 8'h20;
    localparam logic [7:0]  PTC_A_TVAL    = 8'h24;
    // writable bit masks
    localparam logic [31:0] PTC_M_CTRL    = 32'h0000007F;
    localparam logic [31:0] PTC_M_CONST   = 32'h000033FF;
    localparam logic [31:0] PTC_M_PRESET  = 32'h000003FF;
    localparam logic [31:0] PTC_M_CMP     = 32'h00000037;
    // control level bits
    localparam int          PTC_C_LSTART  = 0;
    localparam int          PTC_C_TRESET  = 1;
    localparam int          PTC_C_OSTART  = 2;
    localparam int          PTC_C_CSET    = 3;
    localparam int          PTC_C_CRESET  = 4;
    localparam int          PTC_C_CUP     = 5;
    localparam int          PTC_C_CDOWN   = 6;
    // timer constant layout: count in low bits, time-base digit above
    localparam int          PTC_CW        = 10;
    localparam int          PTC_K_BASE    = 12;
    localparam int          PTC_BW        = 2;
    // compare register layout
    localparam int          PTC_K_OP      = 0;
    localparam int          PTC_OPW       = 3;
    localparam int          PTC_K_FMT     = 4;
    localparam int          PTC_FMTW      = 2;
    localparam logic [2:0]  PTC_OP_EQ     = 3'h0;
    localparam logic [2:0]  PTC_OP_NE     = 3'h1;
    localparam logic [2:0]  PTC_OP_GT     = 3'h2;
    localparam logic [2:0]  PTC_OP_GE     = 3'h3;
    localparam logic [2:0]  PTC_OP_LT     = 3'h4;
    localparam logic [2:0]  PTC_OP_LE     = 3'h5;
    localparam logic [1:0]  PTC_FMT_F16   = 2'h0;
    localparam logic [1:0]  PTC_FMT_F32   = 2'h1;
    localparam logic [1:0]  PTC_FMT_FLT   = 2'h2;
    // status bits
    localparam int          PTC_S_LOUT    = 0;
    localparam int          PTC_S_OOUT    = 1;
    localparam int          PTC_S_RES     = 2;
    localparam int          PTC_S_CCH     = 3;
    localparam int          PTC_S_CCL     = 4;
    localparam int          PTC_S_LRUN    = 5;
    localparam int          PTC_S_ORUN    = 6;
    // count register: bcd field position, timer value register: off timer field
    localparam int          PTC_K_BCD     = 16;
    localparam int          PTC_K_OREM    = 16;
    localparam int          PTC_BCDW      = 12;
    // counter limits and decimal conversion
    localparam logic [9:0]  PTC_CNT_MAX   = 10'h3E7;
    localparam logic [9:0]  PTC_HUNDRED   = 10'h064;
    localparam logic [9:0]  PTC_TEN       = 10'h00A;
    // time base: 0.01 s step, then decades up to 10 s
    localparam int          PTC_CLK_NS    = 4;
    localparam int          PTC_BASE_NS   = 10_000_000;
    localparam int          PTC_BASE_CYC  = PTC_BASE_NS / PTC_CLK_NS;
    localparam int          PTC_PW        = 22;
    localparam int          PTC_NBASE     = 4;
    localparam logic [3:0]  PTC_DEC_LAST  = 4'h9;
endpackage : ptc_pkg

//--- logic/ptc_core.sv
`timescale 1ns/10ps

// Overview of operation
// - latching on-delay timer starts on a 0 to 1 edge of its start level, ignores level 0.
// - latching timer output goes 1 when elapsed, clears only on timer reset.
// - off-delay timer starts running when its start level falls 1 to 0.
// - off-delay timer is held cleared while its start level is 1.
// - off-delay output is 1 while running or while start level is 1.
// - timer constant holds count plus base digit: 0.01 s, 0.1 s, 1 s, 10 s.
// - counter loads preset on set rising edge only; a set level held at 1 does not reload it.
// - set edge flag lives inside the counter state word.
// - counter shows its count as binary and as BCD at once.
// - counter clears while reset level is 1 and stays zero until the next set or count edge.
// - count up adds one, saturating at 999.
// - count up acts only on a 0 to 1 edge of its input.
// - count down subtracts one, saturating at 0.
// - count down acts only on a 0 to 1 edge of its input.
// - separate up and down edge flags in the counter word.
// - equal compare gives 1 on match of the compared words (low words in 16-bit format), first operand against second.
// - not-equal compare gives 1 when the compared words (low words in 16-bit format) differ, 0 when equal; float plus and minus zero give 0.
// - 16-bit compare leaves both accumulator high words untouched.
// - 32-bit fixed and float compares use full accumulator contents.
// - low words compare as signed fixed-point numbers, not raw bits.
// - every compare updates both condition-code bits.
// - ordering compares follow the same accumulator word usage.
module ptc_core #(
    parameter int BASE_CYCLES = ptc_pkg::PTC_BASE_CYC
) (
    // clock, reset, enable
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          ce_i,
    // wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [ptc_pkg::PTC_AW-1:0]    wb_adr_i,
    input  wire logic [ptc_pkg::PTC_SW-1:0]    wb_sel_i,
    input  wire logic [ptc_pkg::PTC_DW-1:0]    wb_dat_i,
    output logic      [ptc_pkg::PTC_DW-1:0]    wb_dat_o,
    output logic                               wb_ack_o,
    // timer results
    output logic                               ltim_out_o,
    output logic                               otim_out_o,
    // counter results
    output logic      [ptc_pkg::PTC_CW-1:0]    binary_count_output_o,
    output logic      [ptc_pkg::PTC_BCDW-1:0]  bcd_count_output_o,
    // compare results
    output logic                               logic_result_o,
    output logic                               condition_code_high_o,
    output logic                               condition_code_low_o
);
    import ptc_pkg::*;

    localparam logic [PTC_PW-1:0] BASE_LAST = PTC_PW'(BASE_CYCLES - 1);

    typedef struct packed {
        logic                  ack;
        logic [PTC_DW-1:0]     rdat;
        logic [PTC_DW-1:0]     ctrl;
        logic [PTC_DW-1:0]     lconst;
        logic [PTC_DW-1:0]     oconst;
        logic [PTC_DW-1:0]     preset;
        logic [PTC_DW-1:0]     acc1;
        logic [PTC_DW-1:0]     acc2;
        logic [PTC_DW-1:0]     cmp;
        logic [PTC_PW-1:0]     pre_cnt;
        logic [3:0]            dec1;
        logic [3:0]            dec2;
        logic [3:0]            dec3;
        logic [PTC_CW-1:0]     lrem;
        logic                  lrun;
        logic                  lout;
        logic                  lflag;
        logic [PTC_CW-1:0]     orem;
        logic                  orun;
        logic                  oout;
        logic                  oflag;
        logic [PTC_CW-1:0]     cnt;
        logic                  fset;
        logic                  fup;
        logic                  fdown;
        logic [PTC_BCDW-1:0]   bcd;
        logic                  lres;
        logic                  cch;
        logic                  ccl;
    } ptc_state_t;

    ptc_state_t q;
    ptc_state_t d;

    function automatic logic [PTC_DW-1:0] ptc_wmask(input logic [PTC_DW-1:0] old_v,
                                                    input logic [PTC_DW-1:0] new_v,
                                                    input logic [PTC_SW-1:0] sel);
        logic [PTC_DW-1:0] r;
        r = old_v;
        for (int i = 0; i < PTC_SW; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : ptc_wmask

    // returns {elapsed, next remaining count}
    function automatic logic [PTC_CW:0] ptc_tstep(input logic [PTC_CW-1:0] rem,
                                                  input logic              tk);
        logic [PTC_CW-1:0] n;
        n = rem;
        if (rem != '0 && tk) begin
            n = rem - 1'b1;
        end
        return {(rem == '0), n};
    endfunction : ptc_tstep

    function automatic logic [PTC_BCDW-1:0] ptc_bcd(input logic [PTC_CW-1:0] b);
        logic [PTC_CW-1:0] h;
        logic [PTC_CW-1:0] t;
        logic [PTC_CW-1:0] o;
        h = b / PTC_HUNDRED;
        t = (b % PTC_HUNDRED) / PTC_TEN;
        o = b % PTC_TEN;
        return {h[3:0], t[3:0], o[3:0]};
    endfunction : ptc_bcd

    // returns {greater, less} of first operand (acc2) against second (acc1)
    function automatic logic [1:0] ptc_order(input logic [PTC_DW-1:0] a,
                                             input logic [PTC_DW-1:0] b,
                                             input logic [1:0]        fmt);
        logic [1:0] r;
        r = 2'b00;
        if (fmt == PTC_FMT_F16) begin
            // only the low words take part
            if ($signed(a[15:0]) > $signed(b[15:0])) r = 2'b10;
            else if ($signed(a[15:0]) < $signed(b[15:0])) r = 2'b01;
        end else if (fmt == PTC_FMT_F32) begin
            if ($signed(a) > $signed(b)) r = 2'b10;
            else if ($signed(a) < $signed(b)) r = 2'b01;
        end else begin
            // sign-magnitude order; plus and minus zero compare equal
            if (a[31] != b[31]) begin
                if (a[30:0] != '0 || b[30:0] != '0) r = a[31] ? 2'b01 : 2'b10;
            end else if (a[30:0] > b[30:0]) begin
                r = a[31] ? 2'b01 : 2'b10;
            end else if (a[30:0] < b[30:0]) begin
                r = a[31] ? 2'b10 : 2'b01;
            end
        end
        return r;
    endfunction : ptc_order

    always_comb begin
        logic                  req;
        logic [PTC_NBASE-1:0]  tk;
        logic [PTC_CW:0]       st;
        logic [1:0]            ord;
        logic [PTC_OPW-1:0]    op;
        logic [PTC_FMTW-1:0]   fmt;
        logic [PTC_DW-1:0]     w;
        logic                  up_e;
        logic                  dn_e;
        req  = wb_cyc_i & wb_stb_i & ~q.ack;
        tk   = '0;
        st   = '0;
        ord  = 2'b00;
        op   = '0;
        fmt  = '0;
        w    = '0;
        up_e = 1'b0;
        dn_e = 1'b0;
        d    = q;

        // bus slave: ack one cycle after the request, dropped the cycle after
        d.ack  = req;
        d.rdat = '0;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                PTC_A_CTRL:   d.rdat = q.ctrl;
                PTC_A_LCONST: d.rdat = q.lconst;
                PTC_A_OCONST: d.rdat = q.oconst;
                PTC_A_PRESET: d.rdat = q.preset;
                PTC_A_ACC1:   d.rdat = q.acc1;
                PTC_A_ACC2:   d.rdat = q.acc2;
                PTC_A_CMP:    d.rdat = q.cmp;
                PTC_A_STATUS: begin
                    d.rdat[PTC_S_LOUT] = q.lout;
                    d.rdat[PTC_S_OOUT] = q.oout;
                    d.rdat[PTC_S_RES]  = q.lres;
                    d.rdat[PTC_S_CCH]  = q.cch;
                    d.rdat[PTC_S_CCL]  = q.ccl;
                    d.rdat[PTC_S_LRUN] = q.lrun;
                    d.rdat[PTC_S_ORUN] = q.orun;
                end
                PTC_A_COUNT: begin
                    d.rdat[PTC_CW-1:0]              = q.cnt;
                    d.rdat[PTC_K_BCD +: PTC_BCDW]   = q.bcd;
                end
                PTC_A_TVAL: begin
                    d.rdat[PTC_CW-1:0]              = q.lrem;
                    d.rdat[PTC_K_OREM +: PTC_CW]    = q.orem;
                end
                default: d.rdat = '0;
            endcase
        end
        if (req && wb_we_i) begin
            case (wb_adr_i)
                PTC_A_CTRL:   d.ctrl   = ptc_wmask(q.ctrl, wb_dat_i, wb_sel_i) & PTC_M_CTRL;
                PTC_A_LCONST: d.lconst = ptc_wmask(q.lconst, wb_dat_i, wb_sel_i) & PTC_M_CONST;
                PTC_A_OCONST: d.oconst = ptc_wmask(q.oconst, wb_dat_i, wb_sel_i) & PTC_M_CONST;
                PTC_A_PRESET: d.preset = ptc_wmask(q.preset, wb_dat_i, wb_sel_i) & PTC_M_PRESET;
                PTC_A_ACC1:   d.acc1   = ptc_wmask(q.acc1, wb_dat_i, wb_sel_i);
                PTC_A_ACC2:   d.acc2   = ptc_wmask(q.acc2, wb_dat_i, wb_sel_i);
                PTC_A_CMP: begin
                    w     = ptc_wmask(q.cmp, wb_dat_i, wb_sel_i) & PTC_M_CMP;
                    d.cmp = w;
                    op    = w[PTC_K_OP +: PTC_OPW];
                    fmt   = w[PTC_K_FMT +: PTC_FMTW];
                    // accumulators are only read here, never written
                    ord   = ptc_order(q.acc2, q.acc1, fmt);
                    d.cch = ord[1];
                    d.ccl = ord[0];
                    case (op)
                        PTC_OP_EQ: d.lres = (ord == 2'b00);
                        PTC_OP_NE: d.lres = (ord != 2'b00);
                        PTC_OP_GT: d.lres = ord[1];
                        PTC_OP_GE: d.lres = ~ord[0];
                        PTC_OP_LT: d.lres = ord[0];
                        PTC_OP_LE: d.lres = ~ord[1];
                        default:   d.lres = 1'b0;
                    endcase
                end
                default: d.ctrl = q.ctrl;
            endcase
        end

        // time base: 0.01 s prescaler, then three decades
        tk[0] = (q.pre_cnt == BASE_LAST);
        tk[1] = tk[0] && (q.dec1 == PTC_DEC_LAST);
        tk[2] = tk[1] && (q.dec2 == PTC_DEC_LAST);
        tk[3] = tk[2] && (q.dec3 == PTC_DEC_LAST);
        d.pre_cnt = tk[0] ? '0 : q.pre_cnt + 1'b1;
        if (tk[0]) d.dec1 = (q.dec1 == PTC_DEC_LAST) ? '0 : q.dec1 + 1'b1;
        if (tk[1]) d.dec2 = (q.dec2 == PTC_DEC_LAST) ? '0 : q.dec2 + 1'b1;
        if (tk[2]) d.dec3 = (q.dec3 == PTC_DEC_LAST) ? '0 : q.dec3 + 1'b1;

        // latching on-delay timer
        d.lflag = q.ctrl[PTC_C_LSTART];
        if (q.ctrl[PTC_C_TRESET]) begin
            d.lrun = 1'b0;
            d.lout = 1'b0;
            d.lrem = '0;
        end else if (q.ctrl[PTC_C_LSTART] && !q.lflag) begin
            d.lrun = 1'b1;
            d.lrem = q.lconst[PTC_CW-1:0];
        end else if (q.lrun) begin
            st     = ptc_tstep(q.lrem, tk[q.lconst[PTC_K_BASE +: PTC_BW]]);
            d.lrem = st[PTC_CW-1:0];
            if (st[PTC_CW]) begin
                d.lrun = 1'b0;
                d.lout = 1'b1;
            end
        end

        // off-delay timer
        d.oflag = q.ctrl[PTC_C_OSTART];
        if (q.ctrl[PTC_C_OSTART]) begin
            d.orun = 1'b0;
            d.orem = '0;
        end else if (q.oflag) begin
            d.orun = 1'b1;
            d.orem = q.oconst[PTC_CW-1:0];
        end else if (q.orun) begin
            st     = ptc_tstep(q.orem, tk[q.oconst[PTC_K_BASE +: PTC_BW]]);
            d.orem = st[PTC_CW-1:0];
            if (st[PTC_CW]) d.orun = 1'b0;
        end
        d.oout = q.ctrl[PTC_C_OSTART] | d.orun;

        // counter; edge flags sit in the counter word itself
        d.fset  = q.ctrl[PTC_C_CSET];
        d.fup   = q.ctrl[PTC_C_CUP];
        d.fdown = q.ctrl[PTC_C_CDOWN];
        up_e    = q.ctrl[PTC_C_CUP] && !q.fup;
        dn_e    = q.ctrl[PTC_C_CDOWN] && !q.fdown;
        if (q.ctrl[PTC_C_CRESET]) begin
            d.cnt = '0;
        end else if (q.ctrl[PTC_C_CSET] && !q.fset) begin
            // preset above the counting range is clipped to the top
            d.cnt = (q.preset[PTC_CW-1:0] > PTC_CNT_MAX) ? PTC_CNT_MAX
                                                         : q.preset[PTC_CW-1:0];
        end else if (up_e && !dn_e) begin
            if (q.cnt < PTC_CNT_MAX) d.cnt = q.cnt + 1'b1;
        end else if (dn_e && !up_e) begin
            if (q.cnt != '0) d.cnt = q.cnt - 1'b1;
        end
        // simultaneous up and down edges cancel
        d.bcd = ptc_bcd(d.cnt);
    end

    // clock enable low freezes bus and time base alike
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign wb_dat_o              = q.rdat;
    assign wb_ack_o              = q.ack;
    assign ltim_out_o            = q.lout;
    assign otim_out_o            = q.oout;
    assign binary_count_output_o = q.cnt;
    assign bcd_count_output_o    = q.bcd;
    assign logic_result_o        = q.lres;
    assign condition_code_high_o = q.cch;
    assign condition_code_low_o  = q.ccl;

endmodule : ptc_core

//--- tb/ptc_core_props.sv
`timescale 1ns/10ps
module ptc_props (
    // clock and bus
    input wire logic                         clk_i,
    input wire logic                         rst_i,
    input wire logic                         ce_i,
    input wire logic                         wb_cyc_i,
    input wire logic                         wb_stb_i,
    input wire logic                         wb_we_i,
    input wire logic [ptc_pkg::PTC_AW-1:0]   wb_adr_i,
    input wire logic [ptc_pkg::PTC_SW-1:0]   wb_sel_i,
    input wire logic [ptc_pkg::PTC_DW-1:0]   wb_dat_i,
    input wire logic [ptc_pkg::PTC_DW-1:0]   wb_dat_o,
    input wire logic                         wb_ack_o,
    // results
    input wire logic                         ltim_out_o,
    input wire logic                         otim_out_o,
    input wire logic [ptc_pkg::PTC_CW-1:0]   binary_count_output_o,
    input wire logic [ptc_pkg::PTC_BCDW-1:0] bcd_count_output_o,
    input wire logic                         logic_result_o,
    input wire logic                         condition_code_high_o,
    input wire logic                         condition_code_low_o
);
    import ptc_pkg::*;
    logic        take;
    logic [6:0]  ctrl_q;
    logic [11:0] bcd_e;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    assign bcd_e = {4'(binary_count_output_o / PTC_HUNDRED),
                    4'((binary_count_output_o / PTC_TEN) % PTC_TEN),
                    4'(binary_count_output_o % PTC_TEN)};
    // shadow of the control levels, since they are not visible at the ports
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 7'h00;
        end else if (take && wb_we_i && wb_adr_i == PTC_A_CTRL && wb_sel_i[0]) begin
            ctrl_q <= wb_dat_i[6:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (take ##1 ce_i |-> wb_ack_o)
        else $error("ack not one cycle after request");
    rd_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data not zero outside ack");
    bcd_track_a:
        assert property (bcd_count_output_o == bcd_e) else $error("bcd output differs from count");
    cnt_ceiling_a:
        assert property (binary_count_output_o <= PTC_CNT_MAX) else $error("count above ceiling");
    cnt_clear_a: assert property (ctrl_q[PTC_C_CRESET] |=> binary_count_output_o == 10'h000)
        else $error("count not zero under reset level");
    cnt_cause_a:
        assert property (!$past(rst_i) && !$stable(binary_count_output_o)
            |-> $past(take && wb_we_i && wb_adr_i == PTC_A_CTRL, 2)) else $error("count moved alone");
    latch_hold_a: assert property (ltim_out_o && !ctrl_q[PTC_C_TRESET] |=> ltim_out_o)
        else $error("latch output dropped without timer reset");
    latch_clear_a: assert property (ctrl_q[PTC_C_TRESET] |=> !ltim_out_o)
        else $error("latch output kept under timer reset");
    off_on_a: assert property (ctrl_q[PTC_C_OSTART] |=> otim_out_o)
        else $error("off timer output low while start high");
    cmp_cause_a:
        assert property (!$past(rst_i) && !$stable({logic_result_o, condition_code_high_o,
            condition_code_low_o}) |-> $past(take && wb_we_i && wb_adr_i == PTC_A_CMP))
        else $error("compare results moved without compare");
    cc_excl_a: assert property (!(condition_code_high_o && condition_code_low_o))
        else $error("both condition codes set");
endmodule : ptc_props

bind ptc_core ptc_props u_props (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ltim_out_o, .otim_out_o,
    .binary_count_output_o, .bcd_count_output_o, .logic_result_o, .condition_code_high_o,
    .condition_code_low_o);

//--- tb/ptc_host.sv
`timescale 1ns/10ps
module ptc_host (
    // clock
    input  wire logic                       clk_i,
    // wishbone master
    output logic                            cyc_o,
    output logic                            stb_o,
    output logic                            we_o,
    output logic [ptc_pkg::PTC_AW-1:0]      adr_o,
    output logic [ptc_pkg::PTC_SW-1:0]      sel_o,
    output logic [ptc_pkg::PTC_DW-1:0]      dat_o,
    input  wire logic [ptc_pkg::PTC_DW-1:0] dat_i,
    input  wire logic                       ack_i
);
    import ptc_pkg::*;
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h00000000;
    end
    // one scan access; waits as long as the slave takes
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        // released data lines must not look like the last word
        dat_o <= ~d;
    endtask : xfer
endmodule : ptc_host

//--- tb/ptc_core_tb.sv
`timescale 1ns/10ps
module ptc_core_tb;
    import ptc_pkg::*;
    localparam int BC = 4;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce = 1'b1;
    logic        cyc, stb, we, ack, lout, oout, lr, cch, ccl;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q, a1, a2;
    logic [9:0]  bin, cnt, pre;
    logic [11:0] bcd;
    logic [6:0]  ctl, nxt;
    logic [2:0]  op;
    logic [1:0]  fm;
    int          n_fail = 0;
    int          num_checks = 0;
    int          seed = 32'h84515B2C;
    int          cyc_n = 0;
    int          t0, per;
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;
    ptc_core #(.BASE_CYCLES(BC)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ltim_out_o(lout), .otim_out_o(oout),
        .binary_count_output_o(bin), .bcd_count_output_o(bcd), .logic_result_o(lr),
        .condition_code_high_o(cch), .condition_code_low_o(ccl));
    ptc_host u_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        u_host.xfer(1'b0, a, 32'h00000000, q);
    endtask : rd
    // control write, then let the levels reach the outputs
    task automatic ctlw(input logic [6:0] v);
        wr(PTC_A_CTRL, {25'h0, v});
        repeat (2) @(posedge clk_i);
    endtask : ctlw
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    function automatic logic [11:0] to_bcd(input logic [9:0] v);
        return {4'(v / PTC_HUNDRED), 4'((v / PTC_TEN) % PTC_TEN), 4'(v % PTC_TEN)};
    endfunction : to_bcd
    function automatic logic [9:0] cnt_next(input logic [9:0] c, input logic [6:0] o,
                                           input logic [6:0] n, input logic [9:0] p);
        logic up, dn;
        up = n[PTC_C_CUP] & ~o[PTC_C_CUP];
        dn = n[PTC_C_CDOWN] & ~o[PTC_C_CDOWN];
        if (n[PTC_C_CRESET]) return 10'h000;
        if (n[PTC_C_CSET] & ~o[PTC_C_CSET]) return (p > PTC_CNT_MAX) ? PTC_CNT_MAX : p;
        if (up & ~dn) return (c == PTC_CNT_MAX) ? c : c + 10'h001;
        if (dn & ~up) return (c == 10'h000) ? c : c - 10'h001;
        return c;
    endfunction : cnt_next
    function automatic logic [2:0] cmp_exp(input logic [2:0] o, input logic [1:0] f,
                                          input logic [31:0] a, input logic [31:0] b);
        logic signed [32:0] x, y;
        logic gt, lt, r;
        x = (f == PTC_FMT_F16) ? 33'(signed'(a[15:0])) : 33'(signed'(a));
        y = (f == PTC_FMT_F16) ? 33'(signed'(b[15:0])) : 33'(signed'(b));
        if (f == PTC_FMT_FLT) x = a[31] ? -33'(a[30:0]) : 33'(a[30:0]);
        if (f == PTC_FMT_FLT) y = b[31] ? -33'(b[30:0]) : 33'(b[30:0]);
        gt = x > y;
        lt = x < y;
        r = (o == PTC_OP_EQ) ? !gt && !lt : (o == PTC_OP_NE) ? gt || lt :
            (o == PTC_OP_GT) ? gt : (o == PTC_OP_GE) ? !lt :
            (o == PTC_OP_LT) ? lt : (o == PTC_OP_LE) ? !gt : 1'b0;
        return {r, gt, lt};
    endfunction : cmp_exp
    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        wrap_up();
    end
    initial begin
        ctl = 7'h00;
        cnt = 10'h000;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(8'h3C, 32'hFFFFFFFF);
        rd(8'h3C);
        chk("unmapped", q, 32'h0);
        wr(PTC_A_STATUS, 32'hFFFFFFFF);
        rd(PTC_A_STATUS);
        chk("status", q, 32'h0);
        for (int i = 0; i < 60; i++) begin
            a2 = $random(seed);
            a1 = (i % 3 == 0) ? a2 : $random(seed);
            if (i % 3 == 1) a1[15:0] = a2[15:0];
            op = 3'(i % 8);
            fm = 2'($unsigned($random(seed)) % 3);
            wr(PTC_A_ACC2, a2);
            wr(PTC_A_ACC1, a1);
            wr(PTC_A_CMP, {26'h0, fm, 1'b0, op});
            chk("compare", {lr, cch, ccl}, cmp_exp(op, fm, a2, a1));
            rd(PTC_A_ACC2);
            chk("acc2 kept", q, a2);
        end
        for (int i = 0; i < 90; i++) begin
            if (i % 10 == 0) begin
                pre = (i % 30 == 0) ? 10'h3FF : (i % 30 == 10) ? 10'h3E5 : 10'h001;
                wr(PTC_A_PRESET, {22'h0, pre});
            end
            nxt = 7'($random(seed)) & 7'h78;
            nxt[PTC_C_CRESET] = ($unsigned($random(seed)) % 8 == 0);
            ctlw(nxt);
            cnt = cnt_next(cnt, ctl, nxt, pre);
            ctl = nxt;
            chk("count bin", bin, cnt);
            chk("count bcd", bcd, to_bcd(cnt));
            rd(PTC_A_COUNT);
            chk("count reg", q, {4'h0, to_bcd(cnt), 6'h00, cnt});
        end
        for (int b = 0; b < PTC_NBASE; b++) begin
            per = BC * (10 ** b);
            wr(PTC_A_LCONST, {18'h0, 2'(b), 12'h003});
            wr(PTC_A_OCONST, {18'h0, 2'(b), 12'h003});
            ctlw(7'h02);
            chk("latch cleared", lout, 1'b0);
            ctlw(7'h04);
            chk("off held", oout, 1'b1);
            ctlw(7'h01);
            t0 = cyc_n;
            ctlw(7'h00);
            while (cyc_n < t0 + 2 * per - 3) @(posedge clk_i);
            chk("latch running", lout, 1'b0);
            chk("off running", oout, 1'b1);
            while (cyc_n < t0 + 3 * per + 6) @(posedge clk_i);
            chk("latch elapsed", lout, 1'b1);
            chk("off elapsed", oout, 1'b0);
        end
        // enable low must hold the timer well past its deadline
        wr(PTC_A_LCONST, 32'h00000003);
        ctlw(7'h02);
        ctlw(7'h01);
        ce <= 1'b0;
        repeat (8 * BC) @(posedge clk_i);
        chk("frozen", lout, 1'b0);
        ce <= 1'b1;
        repeat (3 * BC + 6) @(posedge clk_i);
        chk("thawed", lout, 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("reset", {lout, bin, bcd}, 32'h0);
        wrap_up();
    end
endmodule : ptc_core_tb
